// *** bench/omc_monitor.sv ***
module omc_monitor (
	input wire I_MCLK,
	input wire I_RST_B,
	input wire I_IRQ,
	input wire I_WAIT_EXEC,
	input wire I_ENTER_DEBUG_INSTRUCTION_EXEC,
	input wire I_DBG_CMD_VALID,
	input wire [2:0] I_DBG_CMD,
	input wire O_DBG_DONE,
	input wire [1:0] O_DBG_RESULT,
	input wire O_DBG_ACCESS,
	input wire [2:0] O_MODE,
	input wire O_CPU_CLK_EN,
	input wire O_CPU_FETCH_EN,
	input wire O_CLR_IMASK,
	input wire O_STACK_START,
	input wire O_VEC_REQ,
	input wire [15:0] O_VEC_ADDR,
	input wire O_REG_STANDBY,
	input wire O_LVD_EN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RST_B);
	wire dv = I_DBG_CMD_VALID;
	AST_VEC_FETCH:
	assert property (O_VEC_REQ |-> O_VEC_ADDR == 16'hfffe
		##1 O_MODE == 3'h2 && O_CPU_FETCH_EN) else $error("bad vector");
	AST_LVD_OFF:
	assert property (O_REG_STANDBY |-> !O_LVD_EN) else $error("lvd on");
	AST_ENTER_DEBUG_INSTRUCTION_ENTRY:
	assert property (I_ENTER_DEBUG_INSTRUCTION_EXEC && O_MODE == 3'h2 |=> O_MODE == 3'h4)
		else $error("no background entry");
	AST_BG_NOFETCH:
	assert property (O_MODE == 3'h4 |-> !O_CPU_FETCH_EN)
		else $error("fetch in background");
	AST_NONINTR:
	assert property (dv && O_MODE inside {3'h2, 3'h4} && I_DBG_CMD < 3'h4
		|=> O_DBG_DONE && O_DBG_RESULT == 2'h0) else $error("cmd refused");
	AST_RUN_REFUSE:
	assert property (dv && O_MODE == 3'h2 && I_DBG_CMD[2] |=> O_DBG_DONE
		&& O_DBG_RESULT == 2'h1 && !O_DBG_ACCESS) else $error("not refused");
	AST_WAIT_CLK:
	assert property (O_MODE == 3'h3 |-> !O_CPU_CLK_EN && !O_REG_STANDBY)
		else $error("wait clocks wrong");
	AST_WAIT_IMASK:
	assert property (I_WAIT_EXEC && O_MODE == 3'h2 |=> O_MODE == 3'h3
		&& O_CLR_IMASK ##1 !O_CLR_IMASK) else $error("no mask clear");
	AST_WAIT_IRQ:
	assert property (O_MODE == 3'h3 && I_IRQ && !dv |=> O_MODE == 3'h2
		&& O_STACK_START && O_CPU_CLK_EN) else $error("no irq wake");
	AST_WAIT_CMD:
	assert property (dv && O_MODE == 3'h3 && I_DBG_CMD != 3'h3
		|=> O_DBG_DONE && !O_DBG_ACCESS && O_DBG_RESULT
		== ($past(I_DBG_CMD) == 3'h1 ? 2'h2 : 2'h1)) else $error("wait cmd");
	AST_WAIT_BKGD:
	assert property (dv && I_DBG_CMD == 3'h3 && O_MODE == 3'h3
		|=> O_MODE == 3'h4 && O_DBG_RESULT == 2'h0) else $error("no wake");
endmodule // omc_monitor
bind omc_top omc_monitor mon (.I_MCLK, .I_RST_B, .I_IRQ, .I_WAIT_EXEC,
	.I_ENTER_DEBUG_INSTRUCTION_EXEC, .I_DBG_CMD_VALID, .I_DBG_CMD, .O_DBG_DONE, .O_DBG_RESULT,
	.O_DBG_ACCESS, .O_MODE, .O_CPU_CLK_EN, .O_CPU_FETCH_EN, .O_CLR_IMASK,
	.O_STACK_START, .O_VEC_REQ, .O_VEC_ADDR, .O_REG_STANDBY, .O_LVD_EN);

// *** bench/omc_top_tb.sv ***
`include "omc_regs.vh"
module omc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, cyc = 0, we = 0, pin = 1, sack = 0, irq = 0;
	logic dv = 0, dbg = 1;
	logic [2:0] cmd = 0, c;
	logic [4:0] trg = 0;
	logic [7:0] adr = 0;
	logic [31:0] wd = 0, dat;
	wire [31:0] rdat;
	wire ack, done, clken, fen, stby, low_voltage_detect, fi;
	wire [1:0] res;
	wire [2:0] mode;
	wire [15:0] va;
	int fails = 0, n_checks = 0, s;
	omc_top dut (.I_MCLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc),
		.I_WB_STB(cyc), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h1),
		.I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_MODE_SEL_PIN(pin), .I_SOFT_RST(trg[4]), .I_RST_FROM_DBG(dbg),
		.I_REG_STANDBY_ACK(sack), .I_IRQ(irq), .I_WAIT_EXEC(trg[0]),
		.I_ENTER_DEBUG_INSTRUCTION_EXEC(trg[1]), .I_BDC_BREAK(trg[2]), .I_DBG_BREAK(trg[3]),
		.I_DBG_CMD_VALID(dv), .I_DBG_CMD(cmd), .O_DBG_DONE(done),
		.O_DBG_RESULT(res), .O_DBG_ACCESS(), .O_MODE(mode),
		.O_CPU_CLK_EN(clken), .O_CPU_FETCH_EN(fen), .O_CLR_IMASK(),
		.O_STACK_START(), .O_VEC_REQ(), .O_VEC_ADDR(va),
		.O_REG_STANDBY(stby), .O_LVD_EN(low_voltage_detect), .O_FLASH_INHIBIT(fi));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task end_sim;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (e !== g)
		begin
			fails++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	// ack is read right after the edge, i.e. its sampled value
	task wb(logic w, logic [7:0] a, logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		i = 0;
		do @(posedge clk); while (ack !== 1'b1 && ++i < 20);
		chk("ack", 1, ack);
		dat = rdat;
		cyc <= 0;
	endtask
	task rd(logic [7:0] a, logic [7:0] e);
		wb(0, a, 0);
		chk("rdata", e, dat[7:0]);
	endtask
	task pl(int i);
		@(posedge clk);
		trg <= 5'h1 << i;
		@(posedge clk);
		trg <= 0;
		#1;
	endtask
	task wm(logic [2:0] m);
		int i;
		i = 0;
		while (mode !== m && i++ < 30) @(posedge clk);
		chk("mode", m, mode);
	endtask
	task sr(logic p);
		@(posedge clk);
		pin <= p;
		repeat (5) @(posedge clk);
		pl(4);
		wm(p || !dbg ? 3'h2 : 3'h4);
	endtask
	task dc(logic [2:0] k, logic [1:0] e);
		@(posedge clk);
		dv <= 1;
		cmd <= k;
		@(posedge clk);
		dv <= 0;
		#1;
		chk("done", 1, done);
		chk("result", e, res);
	endtask
	function logic [1:0] ex(logic [2:0] m, logic [2:0] k);
		if (m == 3)
			return k == 1 ? 2'h2 : k == 3 ? 2'h0 : 2'h1;
		return (m == 4 ? k == 7 : k > 3) ? 2'h1 : 2'h0;
	endfunction
	// whole sequence is a few hundred cycles
	initial
	begin
		#100us;
		fails++;
		end_sim;
	end
	initial
	begin
		s = $urandom(1);
		repeat (12) @(posedge clk);
		rst_b <= 1;
		wm(3'h2);
		chk("vector", 16'hfffe, va);
		rd(`OMC_OFS_CTL_ONE, 8'h01);
		rd(`OMC_OFS_MODE, 8'h02);
		rd(8'h0c, 8'h00);
		wb(1, `OMC_OFS_CTL_ONE, 3);
		wb(1, `OMC_OFS_CTL_TWO, 1);
		rd(`OMC_OFS_CTL_TWO, 8'h00);
		wb(1, `OMC_OFS_CTL_ONE, $urandom & 32'hfffffffe);
		wb(1, `OMC_OFS_CTL_TWO, 1);
		repeat (3) @(posedge clk);
		chk("standby", 1, stby);
		chk("lvd", 0, low_voltage_detect);
		chk("flash", 1, fi);
		rd(`OMC_OFS_CTL_TWO, 8'h01);
		sack <= 1;
		repeat (5) @(posedge clk);
		rd(`OMC_OFS_CTL_TWO, 8'h03);
		irq <= 1;
		@(posedge clk);
		irq <= 0;
		repeat (3) @(posedge clk);
		chk("standby", 1, stby);
		wb(1, `OMC_OFS_CTL_TWO, 0);
		repeat (3) @(posedge clk);
		chk("standby", 0, stby);
		sack <= 0;
		repeat (5) @(posedge clk);
		rd(`OMC_OFS_CTL_TWO, 8'h00);
		chk("flash", 0, fi);
		wb(1, `OMC_OFS_CTL_TWO, 5);
		sack <= 1;
		repeat (5) @(posedge clk);
		irq <= 1;
		@(posedge clk);
		irq <= 0;
		repeat (3) @(posedge clk);
		chk("standby", 0, stby);
		sack <= 0;
		repeat (5) @(posedge clk);
		rd(`OMC_OFS_CTL_TWO, 8'h04);
		wb(1, `OMC_OFS_CTL_TWO, 1);
		sack <= 1;
		sr(1);
		chk("standby", 0, stby);
		sack <= 0;
		repeat (5) @(posedge clk);
		rd(`OMC_OFS_CTL_TWO, 8'h00);
		$display("test low power done");
		for (int k = 0; k < 8; k++)
			if (k != 3)
				dc(k, ex(2, k));
		pl(0);
		chk("mode", 3, mode);
		chk("cpuclk", 0, clken);
		for (int k = 0; k < 8; k++)
			if (k != 3)
				dc(k, ex(3, k));
		dc(3, 2'h0);
		wm(3'h4);
		repeat (16)
		begin
			c = $urandom % 8;
			dc(c == 6 ? 3'h7 : c, ex(4, c == 6 ? 3'h7 : c));
		end
		chk("fetch", 0, fen);
		dc(6, 2'h0);
		sr(0);
		dbg <= 0;
		sr(0);
		dbg <= 1;
		sr(1);
		$display("test debug done");
		pl(0);
		@(posedge clk);
		irq <= 1;
		@(posedge clk);
		irq <= 0;
		#1;
		chk("mode", 2, mode);
		chk("cpuclk", 1, clken);
		for (int k = 1; k < 4; k++)
		begin
			pl(k);
			chk("mode", 4, mode);
			sr(1);
		end
		$display("test wait and triggers done");
		@(posedge clk);
		pin <= 0;
		repeat (3) @(posedge clk);
		rst_b <= 0;
		repeat (2) @(posedge clk);
		chk("rstmode", 0, mode);
		rst_b <= 1;
		wm(3'h4);
		$display("test power-on background done");
		end_sim;
	end
endmodule // omc_top_tb

// *** design/omc_top.v ***
// How it works
// - after reset fetch vector at top address, or enter background when mode pin low at power-on or debug soft reset
// - lvd enable on first; lvd auto-disabled
// - request bit set puts regulator standby
// - request bit clear restores full regulation
// - status bit zero means full regulation
// - wake option clear: irq stays low-power
// - wake option set: irq in run mode restores full regulation
// - any reset leaves low-power run, clears request and status bits
// - three triggers enter background mode
// - background mode suspends user instruction fetch
// - non-intrusive commands accepted in run/background
// - cpu/trace/go commands only in background
// - wait stops cpu clock, regulation kept
// - wait entry clears interrupt mask
// - irq in wait restarts with stacking
// - wait accepts only background, status commands
// - background request wakes wait into background
`include "omc_regs.vh"
module omc_top (
	input wire I_MCLK,
	input wire I_RST_B,
	input wire I_WB_CYC,
	input wire I_WB_STB,
	input wire I_WB_WE,
	input wire [7:0] I_WB_ADR,
	input wire [3:0] I_WB_SEL,
	input wire [31:0] I_WB_DAT,
	output reg [31:0] O_WB_DAT,
	output reg O_WB_ACK,
	input wire I_MODE_SEL_PIN,
	input wire I_SOFT_RST,
	input wire I_RST_FROM_DBG,
	input wire I_REG_STANDBY_ACK,
	input wire I_IRQ,
	input wire I_WAIT_EXEC,
	input wire I_ENTER_DEBUG_INSTRUCTION_EXEC,
	input wire I_BDC_BREAK,
	input wire I_DBG_BREAK,
	input wire I_DBG_CMD_VALID,
	input wire [2:0] I_DBG_CMD,
	output reg O_DBG_DONE,
	output reg [1:0] O_DBG_RESULT,
	output reg O_DBG_ACCESS,
	output reg [2:0] O_MODE,
	output reg O_CPU_CLK_EN,
	output reg O_CPU_FETCH_EN,
	output reg O_CLR_IMASK,
	output reg O_STACK_START,
	output reg O_VEC_REQ,
	output reg [15:0] O_VEC_ADDR,
	output reg O_REG_STANDBY,
	output reg O_LVD_EN,
	output reg O_FLASH_INHIBIT
);

reg pin_s1;
reg pin_s2;
reg rack_s1;
reg rack_s2;
reg [2:0] state;
reg [2:0] next_state;
reg chk_pin;
reg low_voltage_detect_enable;
reg low_voltage_detect_stop_enable;
reg low_power_run_request;
reg low_power_run_status;
reg wake;
reg waking;
reg next_lpr;
reg next_waking;
reg [1:0] next_result;
reg next_done;
reg next_access;
reg next_clr;
reg next_stack;
reg next_vec;
wire wb_req;
wire wb_wr;
wire wake_irq;
wire bdm_trig;
reg [31:0] rd_data;

// command class decode used in run mode only
function is_nonintr;
	input [2:0] c;
	begin
		is_nonintr = (c == `OMC_CMD_MEM) || (c == `OMC_CMD_MEMST) ||
			(c == `OMC_CMD_DREG) || (c == `OMC_CMD_BKGD);
	end
endfunction

assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
assign wb_wr = wb_req & I_WB_WE & I_WB_SEL[0];
assign wake_irq = low_power_run_request & wake & I_IRQ & (state == `OMC_ST_RUN);
assign bdm_trig = I_ENTER_DEBUG_INSTRUCTION_EXEC | I_BDC_BREAK | I_DBG_BREAK;

// no reset: pin level must be ready at first edge after power-on
always @(posedge I_MCLK)
begin
	pin_s1 <= I_MODE_SEL_PIN;
	pin_s2 <= pin_s1;
end

// regulator feedback comes from outside the clock domain
always @(posedge I_MCLK or negedge I_RST_B)
begin
	if (!I_RST_B)
	begin
		rack_s1 <= 1'b0;
		rack_s2 <= 1'b0;
	end
	else
	begin
		rack_s1 <= I_REG_STANDBY_ACK;
		rack_s2 <= rack_s1;
	end
end

always @*
begin
	next_state = state;
	next_result = `OMC_RES_DONE;
	next_done = 1'b0;
	next_access = 1'b0;
	next_clr = 1'b0;
	next_stack = 1'b0;
	next_vec = 1'b0;
	case (state)
	`OMC_ST_INIT:
	begin
		if (chk_pin && !pin_s2)
			next_state = `OMC_ST_BDM;
		else
		begin
			next_state = `OMC_ST_VEC;
			next_vec = 1'b1;
		end
	end
	`OMC_ST_VEC:
		next_state = `OMC_ST_RUN;
	`OMC_ST_RUN:
	begin
		if (I_DBG_CMD_VALID)
		begin
			next_done = 1'b1;
			if (is_nonintr(I_DBG_CMD))
				next_access = (I_DBG_CMD != `OMC_CMD_BKGD);
			else
				next_result = `OMC_RES_REFUSE;
		end
		if (bdm_trig ||
			(I_DBG_CMD_VALID && I_DBG_CMD == `OMC_CMD_BKGD))
			next_state = `OMC_ST_BDM;
		else if (I_WAIT_EXEC)
		begin
			next_state = `OMC_ST_WAIT;
			next_clr = 1'b1;
		end
	end
	`OMC_ST_WAIT:
	begin
		if (I_DBG_CMD_VALID)
		begin
			next_done = 1'b1;
			if (I_DBG_CMD == `OMC_CMD_MEMST)
				next_result = `OMC_RES_WAITERR;
			else if (I_DBG_CMD != `OMC_CMD_BKGD)
				next_result = `OMC_RES_REFUSE;
		end
		if (I_DBG_CMD_VALID && I_DBG_CMD == `OMC_CMD_BKGD)
			next_state = `OMC_ST_BDM;
		else if (I_IRQ)
		begin
			next_state = `OMC_ST_RUN;
			next_stack = 1'b1;
		end
	end
	`OMC_ST_BDM:
	begin
		if (I_DBG_CMD_VALID)
		begin
			next_done = 1'b1;
			next_access = (I_DBG_CMD != `OMC_CMD_BKGD) &&
				(I_DBG_CMD <= `OMC_CMD_GO);
			if (I_DBG_CMD > `OMC_CMD_GO)
				next_result = `OMC_RES_REFUSE;
			if (I_DBG_CMD == `OMC_CMD_GO)
				next_state = `OMC_ST_RUN;
		end
	end
	default:
		next_state = `OMC_ST_INIT;
	endcase
end

// low-power request: software write, irq wake, reset all act on it
always @*
begin
	next_lpr = low_power_run_request;
	next_waking = waking & low_power_run_status;
	if (wb_wr && I_WB_ADR == `OMC_OFS_CTL_TWO)
	begin
		if (!I_WB_DAT[`OMC_B_LPRQ])
			next_lpr = 1'b0;
		else if (!(low_voltage_detect_enable && low_voltage_detect_stop_enable))
			next_lpr = 1'b1;
	end
	if (wake_irq)
	begin
		next_lpr = 1'b0;
		next_waking = 1'b1;
	end
	if (I_SOFT_RST)
		next_lpr = 1'b0;
end

always @(posedge I_MCLK or negedge I_RST_B)
begin
	if (!I_RST_B)
	begin
		state <= `OMC_ST_INIT;
		chk_pin <= 1'b1;
		low_voltage_detect_enable <= 1'b1;
		low_voltage_detect_stop_enable <= 1'b0;
		low_power_run_request <= `OMC_RST_BIT;
		low_power_run_status <= `OMC_RST_BIT;
		wake <= `OMC_RST_BIT;
		waking <= 1'b0;
	end
	else
	begin
		if (I_SOFT_RST)
		begin
			state <= `OMC_ST_INIT;
			chk_pin <= I_RST_FROM_DBG;
			low_power_run_status <= 1'b0;
			waking <= 1'b0;
		end
		else
		begin
			state <= next_state;
			low_power_run_status <= rack_s2;
			waking <= next_waking;
		end
		low_power_run_request <= next_lpr;
		if (wb_wr && I_WB_ADR == `OMC_OFS_CTL_ONE)
		begin
			low_voltage_detect_enable <= I_WB_DAT[`OMC_B_LOW_VOLTAGE_DETECT_ENABLE];
			low_voltage_detect_stop_enable <= I_WB_DAT[`OMC_B_LOW_VOLTAGE_DETECT_STOP_ENABLE];
		end
		if (wb_wr && I_WB_ADR == `OMC_OFS_CTL_TWO)
			wake <= I_WB_DAT[`OMC_B_WAKE];
	end
end

always @*
begin
	rd_data = 32'h0;
	case (I_WB_ADR)
	`OMC_OFS_CTL_ONE:
	begin
		rd_data[`OMC_B_LOW_VOLTAGE_DETECT_ENABLE] = low_voltage_detect_enable;
		rd_data[`OMC_B_LOW_VOLTAGE_DETECT_STOP_ENABLE] = low_voltage_detect_stop_enable;
	end
	`OMC_OFS_CTL_TWO:
	begin
		rd_data[`OMC_B_LPRQ] = low_power_run_request;
		rd_data[`OMC_B_LOW_POWER_RUN_STATUS] = low_power_run_status;
		rd_data[`OMC_B_WAKE] = wake;
	end
	`OMC_OFS_MODE:
		rd_data[2:0] = state;
	default:
		rd_data = 32'h0;
	endcase
end

// one-wait-state slave; unmapped reads return zero
always @(posedge I_MCLK or negedge I_RST_B)
begin
	if (!I_RST_B)
	begin
		O_WB_ACK <= 1'b0;
		O_WB_DAT <= 32'h0;
	end
	else
	begin
		O_WB_ACK <= wb_req;
		O_WB_DAT <= wb_req ? rd_data : 32'h0;
	end
end

always @(posedge I_MCLK or negedge I_RST_B)
begin
	if (!I_RST_B)
	begin
		O_DBG_DONE <= 1'b0;
		O_DBG_RESULT <= `OMC_RES_DONE;
		O_DBG_ACCESS <= 1'b0;
		O_MODE <= `OMC_ST_INIT;
		O_CPU_CLK_EN <= 1'b0;
		O_CPU_FETCH_EN <= 1'b0;
		O_CLR_IMASK <= 1'b0;
		O_STACK_START <= 1'b0;
		O_VEC_REQ <= 1'b0;
		O_VEC_ADDR <= `OMC_VECTOR;
		O_REG_STANDBY <= 1'b0;
		O_LVD_EN <= 1'b0;
		O_FLASH_INHIBIT <= 1'b0;
	end
	else
	begin
		O_DBG_DONE <= next_done & ~I_SOFT_RST;
		O_DBG_RESULT <= next_result;
		O_DBG_ACCESS <= next_access & ~I_SOFT_RST;
		O_MODE <= I_SOFT_RST ? `OMC_ST_INIT : next_state;
		O_CPU_CLK_EN <= ~I_SOFT_RST &
			(next_state != `OMC_ST_WAIT);
		O_CPU_FETCH_EN <= ~I_SOFT_RST &
			(next_state == `OMC_ST_RUN) &
			~next_waking;
		O_CLR_IMASK <= next_clr & ~I_SOFT_RST;
		O_STACK_START <= next_stack & ~I_SOFT_RST;
		O_VEC_REQ <= next_vec & ~I_SOFT_RST;
		O_VEC_ADDR <= `OMC_VECTOR;
		O_REG_STANDBY <= next_lpr &
			(next_state != `OMC_ST_WAIT);
		O_LVD_EN <= low_voltage_detect_enable & ~next_lpr & ~low_power_run_status;
		O_FLASH_INHIBIT <= next_lpr | low_power_run_status;
	end
end

endmodule // omc_top

// *** inc/omc_regs.vh ***
`ifndef OMC_REGS_VH
`define OMC_REGS_VH
`define OMC_ADR_W 8
`define OMC_OFS_CTL_ONE 8'h00
`define OMC_OFS_CTL_TWO 8'h04
`define OMC_OFS_MODE 8'h08
`define OMC_B_LOW_VOLTAGE_DETECT_ENABLE 0
`define OMC_B_LOW_VOLTAGE_DETECT_STOP_ENABLE 1
`define OMC_B_LPRQ 0
`define OMC_B_LOW_POWER_RUN_STATUS 1
`define OMC_B_WAKE 2
`define OMC_RST_BIT 1'b0
`define OMC_VECTOR 16'hfffe
`define OMC_ST_INIT 3'h0
`define OMC_ST_VEC 3'h1
`define OMC_ST_RUN 3'h2
`define OMC_ST_WAIT 3'h3
`define OMC_ST_BDM 3'h4
`define OMC_CMD_MEM 3'h0
`define OMC_CMD_MEMST 3'h1
`define OMC_CMD_DREG 3'h2
`define OMC_CMD_BKGD 3'h3
`define OMC_CMD_CPUREG 3'h4
`define OMC_CMD_TRACE 3'h5
`define OMC_CMD_GO 3'h6
`define OMC_RES_DONE 2'h0
`define OMC_RES_REFUSE 2'h1
`define OMC_RES_WAITERR 2'h2
`endif
